// ==== verilog/pd_bmc_pkg.sv ====
// shared constants and carrier types for the biphase-mark line coder
package pd_bmc_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int UI_NS         = 3333;
  localparam int UI_CYC        = UI_NS / CLK_PERIOD_NS;
  localparam int HALF_CYC      = UI_CYC / 2;
  localparam int RX_SPLIT_CYC  = (UI_CYC * 3) / 4;
  localparam int RX_GAP_MAX    = (UI_CYC * 3) / 2;
  localparam int CNT_W         = 10;

  localparam logic [CNT_W-1:0] UI_LAST   = CNT_W'(UI_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] RX_SPLIT  = CNT_W'(RX_SPLIT_CYC);
  localparam logic [CNT_W-1:0] RX_MAX    = CNT_W'(RX_GAP_MAX);

  // ------------------------------------------------------------------
  // drive level and reset values
  // ------------------------------------------------------------------
  localparam int              LVL_W    = 4;
  localparam logic [LVL_W-1:0] LVL_RST = 4'h8;
  localparam logic             ORIENT_RST = 1'b0;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic data;
    logic last;
  } tx_req_t;

  typedef struct packed {
    logic valid;
    logic data;
  } rx_bit_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LEAD,
    TX_CELL,
    TX_TAIL
  } tx_state_t;

endpackage

// ==== verilog/bmc_rx_decoder.sv ====
// biphase-mark receive decoder timing gaps between line edges
`timescale 1ns/10ps
module bmc_rx_decoder
  import pd_bmc_pkg::*;
(
  input  wire logic    i_clk_sys,
  input  wire logic    i_rst_b,
  input  wire logic    i_line,
  input  wire logic    i_listen,
  output rx_bit_t      o_rx,
  output logic         o_busy
);

  logic             prev_reg, prev_next;
  logic             lock_reg, lock_next;
  logic             pend_reg, pend_next;
  logic [CNT_W-1:0] gap_reg,  gap_next;
  rx_bit_t          rx_reg,   rx_next;
  logic [1:0]       settle_reg, settle_next;
  logic             edge_seen;

  // the synchroniser and prev_reg hold stale levels for a few cycles after
  // reset or after our own release; edges wait until they have settled
  assign edge_seen = i_listen && (settle_reg == 2'h3)
                  && (i_line != prev_reg);

  always_comb begin
    prev_next = i_line;
    settle_next = (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
    lock_next = lock_reg;
    pend_next = pend_reg;
    gap_next  = (gap_reg == RX_MAX) ? gap_reg : gap_reg + CNT_W'(1);
    rx_next   = '0;
    if (!i_listen) begin
      settle_next = 2'h0;
      lock_next = 1'b0;
      pend_next = 1'b0;
      gap_next  = '0;
    end else if (edge_seen) begin
      gap_next = '0;
      if (lock_reg && gap_reg < RX_SPLIT) begin
        // two short gaps make a one
        if (pend_reg) begin
          rx_next   = '{valid: 1'b1, data: 1'b1};
          pend_next = 1'b0;
        end else begin
          pend_next = 1'b1;
        end
      end else if (lock_reg && gap_reg < RX_MAX) begin
        rx_next   = '{valid: 1'b1, data: 1'b0};
        pend_next = 1'b0;
      end else begin
        // a lost opening edge just means locking one edge later
        lock_next = 1'b1;
        pend_next = 1'b0;
      end
    end else if (gap_reg == RX_MAX) begin
      lock_next = 1'b0;
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= 1'b0;
      lock_reg <= 1'b0;
      pend_reg <= 1'b0;
      gap_reg  <= '0;
      settle_reg <= 2'h0;
      rx_reg   <= '0;
    end else begin
      prev_reg <= prev_next;
      lock_reg <= lock_next;
      pend_reg <= pend_next;
      gap_reg  <= gap_next;
      settle_reg <= settle_next;
      rx_reg   <= rx_next;
    end
  end

  assign o_rx   = rx_reg;
  assign o_busy = lock_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  AST_RX_ONE: assert property (
    edge_seen && lock_reg && gap_reg < RX_SPLIT && pend_reg
    |=> o_rx.valid && o_rx.data)
    else $error("short gap pair did not yield a one");

  AST_RX_ZERO: assert property (
    edge_seen && lock_reg && gap_reg >= RX_SPLIT && gap_reg < RX_MAX
    |=> o_rx.valid && !o_rx.data)
    else $error("full gap did not yield a zero");

  AST_RX_FIRST_EDGE: assert property (
    edge_seen && !lock_reg |=> !o_rx.valid && o_busy)
    else $error("first edge not used to lock");

  COV_RX_ONE: cover property (o_rx.valid && o_rx.data);
  COV_RX_ZERO: cover property (o_rx.valid && !o_rx.data);

endmodule // bmc_rx_decoder

// ==== verilog/pd_bmc_phy.sv ====
// biphase-mark physical layer for the two configuration lines
//
// Contract
// - toggle level at every bit-cell start
// - ones toggle mid-cell, zeros do not
// - preamble starts by driving low level
// - receiver locks despite missing first edge
// - closing edge after final end bit
// - drive only while sending, else release
// - only one talker; others stay released
// - use only the orientation-selected line
// - software drive level sets output levels
`timescale 1ns/10ps
module pd_bmc_phy
  import pd_bmc_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_b,
  input  wire logic             i_orient,
  input  wire logic [LVL_W-1:0] i_tx_level,
  input  wire tx_req_t          i_tx_req,
  output logic                  o_tx_ready,
  output logic                  o_tx_busy,
  output rx_bit_t               o_rx,
  output logic                  o_rx_busy,
  output logic [LVL_W-1:0]      o_tx_peak_level,
  input  wire logic             i_config_line_one,
  output logic                  o_config_line_one,
  output logic                  o_config_line_one_oe,
  input  wire logic             i_config_line_two,
  output logic                  o_config_line_two,
  output logic                  o_config_line_two_oe
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] sync_one_reg;
  logic [1:0] sync_two_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_one_reg <= 2'h0;
      sync_two_reg <= 2'h0;
    end else begin
      sync_one_reg <= {sync_one_reg[0], i_config_line_one};
      sync_two_reg <= {sync_two_reg[0], i_config_line_two};
    end
  end

  // ------------------------------------------------------------------
  // transmit state
  // ------------------------------------------------------------------
  tx_state_t        state_reg,  state_next;
  logic [CNT_W-1:0] cnt_reg,    cnt_next;
  logic             line_reg,   line_next;
  logic             bit_reg,    bit_next;
  logic             last_reg,   last_next;
  logic             orient_reg, orient_next;
  logic             drv1_reg,   drv1_next;
  logic             drv2_reg,   drv2_next;
  logic [LVL_W-1:0] lvl_reg,    lvl_next;
  logic             rx_line;
  logic             rx_busy;
  logic             take;
  logic             cell_end;

  assign cell_end = (state_reg == TX_CELL) && (cnt_reg == UI_LAST);

  // a frame may only open on a quiet line; later bits are taken at the
  // end of each cell so the core sees one ready per bit
  assign o_tx_ready = ((state_reg == TX_IDLE) && !rx_busy)
                    || (cell_end && !last_reg);
  assign take       = o_tx_ready && i_tx_req.valid;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    line_next   = line_reg;
    bit_next    = bit_reg;
    last_next   = last_reg;
    orient_next = orient_reg;
    lvl_next    = lvl_reg;
    drv1_next   = drv1_reg;
    drv2_next   = drv2_reg;
    unique case (state_reg)
      TX_IDLE: begin
        // receive follows the pin while idle; a frame holds it fixed
        orient_next = i_orient;
        if (take) begin
          state_next  = TX_LEAD;
          cnt_next    = '0;
          line_next   = 1'b0;
          bit_next    = i_tx_req.data;
          last_next   = i_tx_req.last;
          lvl_next    = i_tx_level;
          drv1_next   = !i_orient;
          drv2_next   = i_orient;
        end
      end
      TX_LEAD: begin
        if (cnt_reg == HALF_LAST) begin
          state_next = TX_CELL;
          cnt_next   = '0;
          line_next  = !line_reg;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      TX_CELL: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg == HALF_LAST && bit_reg) begin
          line_next = !line_reg;
        end
        if (cell_end) begin
          cnt_next  = '0;
          line_next = !line_reg;
          if (take) begin
            bit_next  = i_tx_req.data;
            last_next = i_tx_req.last;
          end else begin
            // a missing bit ends the frame as if it were the last
            state_next = TX_TAIL;
          end
        end
      end
      TX_TAIL: begin
        if (cnt_reg == HALF_LAST) begin
          state_next = TX_IDLE;
          cnt_next   = '0;
          drv1_next  = 1'b0;
          drv2_next  = 1'b0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg  <= TX_IDLE;
      cnt_reg    <= '0;
      line_reg   <= 1'b0;
      bit_reg    <= 1'b0;
      last_reg   <= 1'b0;
      orient_reg <= ORIENT_RST;
      lvl_reg    <= LVL_RST;
      drv1_reg   <= 1'b0;
      drv2_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      line_reg   <= line_next;
      bit_reg    <= bit_next;
      last_reg   <= last_next;
      orient_reg <= orient_next;
      lvl_reg    <= lvl_next;
      drv1_reg   <= drv1_next;
      drv2_reg   <= drv2_next;
    end
  end

  assign o_tx_busy            = (state_reg != TX_IDLE);
  assign o_tx_peak_level      = lvl_reg;
  assign o_config_line_one    = line_reg;
  assign o_config_line_two    = line_reg;
  assign o_config_line_one_oe = drv1_reg;
  assign o_config_line_two_oe = drv2_reg;

  // ------------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------------
  // listen on the registered orientation; our own frames are not decoded
  assign rx_line = orient_reg ? sync_two_reg[1] : sync_one_reg[1];

  bmc_rx_decoder u_rx (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_line    (rx_line),
    .i_listen  (!(drv1_reg || drv2_reg)),
    .o_rx      (o_rx),
    .o_busy    (rx_busy)
  );

  assign o_rx_busy = rx_busy;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  AST_CELL_EDGE: assert property (
    cell_end |=> $changed(line_reg))
    else $error("no edge at bit cell boundary");

  AST_ONE_MID: assert property (
    state_reg == TX_CELL && cnt_reg == HALF_LAST && bit_reg
    |=> $changed(line_reg))
    else $error("one bit lacks mid-cell edge");

  AST_ZERO_FLAT: assert property (
    state_reg == TX_CELL && cnt_reg == HALF_LAST && !bit_reg
    |=> $stable(line_reg))
    else $error("zero bit has mid-cell edge");

  AST_LEAD_LOW: assert property (
    $rose(o_tx_busy) |-> !line_reg ##1 (!line_reg)[*8])
    else $error("frame did not open at low level");

  AST_CLOSE_EDGE: assert property (
    state_reg == TX_TAIL && $past(state_reg) == TX_CELL
    |-> $changed(line_reg))
    else $error("missing closing edge");

  AST_RELEASE: assert property (
    state_reg == TX_IDLE |-> !drv1_reg && !drv2_reg)
    else $error("driver enabled while idle");

  AST_ONE_DRIVER: assert property (
    !(o_config_line_one_oe && o_config_line_two_oe))
    else $error("both lines driven");

  AST_ORIENT: assert property (
    o_tx_busy |-> (drv2_reg == orient_reg) && (drv1_reg != orient_reg))
    else $error("driving the unselected line");

  AST_LEVEL_HOLD: assert property (
    o_tx_busy && $past(o_tx_busy) |-> $stable(o_tx_peak_level))
    else $error("drive level changed mid-frame");

  AST_NO_CONTEND: assert property (
    state_reg == TX_IDLE && rx_busy |=> state_reg == TX_IDLE)
    else $error("frame started on active line");

  COV_FRAME: cover property ($fell(o_tx_busy));
  COV_DEFER: cover property (i_tx_req.valid && rx_busy && !o_tx_busy);

endmodule // pd_bmc_phy

// ==== verif/pd_partner_model.sv ====
// far-end port model that sends biphase-mark frames on a shared line
`timescale 1ns/10ps
module pd_partner_model
  import pd_bmc_pkg::*;
(
  input  wire logic i_clk_sys,
  output logic      o_line,
  output logic      o_line_oe
);
  initial begin
    o_line    = 1'b0;
    o_line_oe = 1'b0;
  end

  // no low lead-in: the first cell edge leaves the idle level directly,
  // so the receiver has to survive losing it
  task automatic send(input logic [15:0] bits, input int n);
    logic lvl;
    lvl = 1'b1;
    for (int k = 0; k < n; k++) begin
      lvl = ~lvl;
      o_line    <= lvl;
      o_line_oe <= 1'b1;
      repeat (HALF_CYC) @(posedge i_clk_sys);
      if (bits[k]) begin
        lvl = ~lvl;
        o_line <= lvl;
      end
      repeat (UI_CYC - HALF_CYC) @(posedge i_clk_sys);
    end
    o_line <= ~lvl;
    // release after half a cell: the gap to the bias edge stays short,
    // so it can never complete a bit at the receiver
    repeat (HALF_CYC) @(posedge i_clk_sys);
    o_line_oe <= 1'b0;
    o_line    <= lvl;
  endtask
endmodule // pd_partner_model

// ==== verif/tb_pd_bmc_phy.sv ====
// self-checking bench for the biphase-mark line coder
`timescale 1ns/10ps
module tb_pd_bmc_phy
  import pd_bmc_pkg::*;
;
  localparam logic [15:0] PAT   = 16'h0a63;
  localparam int          LIMIT = 30000;

  logic             clk;
  logic             rst_b;
  logic             orient;
  logic [LVL_W-1:0] level;
  tx_req_t          req;
  logic             tx_ready;
  logic             tx_busy;
  rx_bit_t          rx;
  logic             rx_busy;
  logic [LVL_W-1:0] peak;
  logic             line1;
  logic             oe1;
  logic             line2;
  logic             oe2;
  logic             p_line;
  logic             p_oe;
  logic             p_two;
  logic             sel_two;
  logic             rec;
  wire              cc_one;
  wire              cc_two;
  int               err_total;
  int               samples_checked;
  int               cyc;
  int               clash;
  logic [2:0]       trace[$];
  logic             rxq[$];

  pd_bmc_phy i_dut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_orient(orient),
    .i_tx_level(level), .i_tx_req(req), .o_tx_ready(tx_ready),
    .o_tx_busy(tx_busy), .o_rx(rx), .o_rx_busy(rx_busy),
    .o_tx_peak_level(peak), .i_config_line_one(cc_one),
    .o_config_line_one(line1), .o_config_line_one_oe(oe1),
    .i_config_line_two(cc_two), .o_config_line_two(line2),
    .o_config_line_two_oe(oe2)
  );

  pd_partner_model i_partner (
    .i_clk_sys(clk), .o_line(p_line), .o_line_oe(p_oe)
  );

  // released lines rest at the bias level, seen here as high
  assign cc_one = oe1 ? line1 : (p_oe && !p_two) ? p_line : 1'b1;
  assign cc_two = oe2 ? line2 : (p_oe && p_two) ? p_line : 1'b1;

  always #5 clk = ~clk;

  // --------------------------------------------------------------------
  // monitors
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (rx.valid === 1'b1) rxq.push_back(rx.data);
    if (p_oe && (p_two ? oe2 : oe1)) clash++;
    if (rec) trace.push_back(sel_two ? {oe2, oe1, line2} : {oe1, oe2, line1});
    if (cyc == LIMIT) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_take();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (!(tx_ready === 1'b1 && req.valid) && i < 2000);
    chk(i < 2000, 1'b1);
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    repeat (3) @(posedge clk);
    while (tx_busy !== 1'b0 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    chk(i < 3000, 1'b1);
    repeat (4) @(posedge clk);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    chk(tx_ready, 1'b1);
    chk({oe1, oe2}, 2'b00);
    chk(peak, LVL_RST);
    $display("test reset done");
  endtask

  task automatic t_tx(input logic [15:0] bits, input int n,
                      input logic ov, input logic [LVL_W-1:0] lv);
    int   t0;
    int   s;
    int   non;
    logic oth;
    logic mid;
    trace.delete();
    t0 = -1;
    non = 0;
    oth = 1'b0;
    sel_two = ov;
    orient <= ov;
    level <= lv;
    rec = 1'b1;
    for (int k = 0; k < n; k++) begin
      req <= '{1'b1, bits[k], k == n - 1};
      wait_take();
    end
    req <= '0;
    wait_idle();
    rec = 1'b0;
    foreach (trace[i]) begin
      if (trace[i][2] && t0 < 0) t0 = i;
      non += trace[i][2];
      oth |= trace[i][1];
    end
    chk(trace[t0][0], 1'b0);
    for (int k = 0; k <= n; k++) begin
      s = t0 + HALF_CYC + k * UI_CYC;
      chk(trace[s][0] ^ trace[s-1][0], 1'b1);
      mid = trace[s+HALF_CYC][0] ^ trace[s+HALF_CYC-1][0];
      if (k < n) chk(mid, bits[k]);
    end
    chk(non, 2 * HALF_CYC + n * UI_CYC);
    chk(oth, 1'b0);
    chk(peak, lv);
    chk(ov ? cc_two : cc_one, 1'b1);
    $display("test tx orient %0d done", ov);
  endtask

  // a request raised mid-frame must wait until the far side goes quiet
  task automatic t_rx(input logic ov, input int exp_n);
    rxq.delete();
    clash = 0;
    p_two = 1'b1;
    orient <= ov;
    @(posedge clk);
    fork
      i_partner.send(PAT, 12);
      begin
        repeat (2 * UI_CYC) @(posedge clk);
        chk(rx_busy, exp_n > 0);
        if (exp_n > 0) begin
          chk(tx_ready, 1'b0);
          req <= '{1'b1, 1'b0, 1'b1};
        end
      end
    join
    if (exp_n > 0) begin
      wait_take();
      req <= '0;
      wait_idle();
    end
    chk(rxq.size(), exp_n);
    for (int k = 0; k < exp_n; k++) begin
      chk(rxq[k], PAT[k]);
    end
    chk(clash, 0);
    $display("test rx orient %0d done", ov);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    orient = 1'b0;
    level = LVL_RST;
    req = '0;
    p_two = 1'b1;
    sel_two = 1'b0;
    rec = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tx(16'h000d, 4, 1'b0, 4'h3);
    t_tx(16'h0000, 1, 1'b1, 4'hf);
    t_rx(1'b1, 12);
    t_rx(1'b0, 0);
    complete_run();
  end
endmodule // tb_pd_bmc_phy
